// File: logic/eme_extend.sv
// Measurement extend leaf: checks, header build and hash-step sequencing
//
// The plain strobed port and the placing of the registers were decided locally.
`default_nettype none
module eme_extend (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    // Leaf request and operands
    input wire logic op_req,
    input wire logic [7:0] op_leaf,
    input wire logic [1:0] op_priv,
    input wire logic op_mode64,
    input wire logic [63:0] op_ctrl_addr,
    input wire logic [63:0] op_chunk_addr,
    input wire logic op_ctrl_seg_ok,
    input wire logic op_chunk_seg_ok,
    // Page-cache lookup results for the two operands
    input wire logic pc_ctrl_in_cache,
    input wire logic pc_chunk_in_cache,
    input wire logic pc_map_valid,
    input wire logic [7:0] pc_map_type,
    input wire logic pc_owner_match,
    input wire logic pc_initialized,
    input wire logic pc_map_busy,
    input wire logic pc_meas_busy,
    input wire logic pc_init_busy,
    input wire logic [63:0] pc_enclave_addr,
    input wire logic [63:0] pc_base_addr,
    input wire logic [2047:0] pc_chunk_data,
    // Outcome
    output logic op_busy,
    output logic op_done,
    output logic op_gp_fault,
    output logic op_pf_fault,
    output logic [63:0] op_pf_addr,
    // Hash-update engine
    output logic hsh_valid,
    output logic [511:0] hsh_block,
    input wire logic hsh_ready
);
    import eme_pkg::*;

    typedef struct packed {
        eme_state_t st;
        logic [1:0] idx;
        logic en;
        logic [63:0] cnt;
        logic [63:0] ofs;
        logic [2047:0] chunk;
        logic [511:0] blk;
        logic done;
        logic gp;
        logic pf;
        logic last_gp;
        logic last_pf;
        logic [63:0] pf_addr;
        logic [31:0] rdata;
    } eme_regs_t;

    eme_regs_t s_r;
    eme_regs_t s_nxt;
    logic take;
    logic ctrl_canon;
    logic chunk_canon;
    logic addr_gp;
    logic type_ok;
    logic [63:0] ofs_calc;
    logic hsh_acc;
    logic [10:0] nxt_base;

    // Request taken only when enabled and idle, for this leaf only
    assign take = op_req && (op_leaf == EME_LEAF_CODE)
        && (s_r.st == EME_IDLE) && s_r.en;

    // Canonical form: bits 63:47 all equal
    assign ctrl_canon = &op_ctrl_addr[63:47] || ~|op_ctrl_addr[63:47];
    assign chunk_canon = &op_chunk_addr[63:47] || ~|op_chunk_addr[63:47];

    // Segment limit in legacy mode, canonical form in 64-bit mode
    assign addr_gp = op_mode64 ? (!ctrl_canon || !chunk_canon)
        : (!op_ctrl_seg_ok || !op_chunk_seg_ok);

    // Only regular and thread-control pages may be measured
    assign type_ok = (pc_map_type == EME_PT_REGULAR)
        || (pc_map_type == EME_PT_THREAD);

    // Offset of the chunk within the enclave
    assign ofs_calc = pc_enclave_addr - pc_base_addr
        + {52'h0, op_chunk_addr[11:0] & EME_PAGE_MASK};

    assign hsh_acc = hsh_valid && hsh_ready;

    // Bit position of the chunk that follows the one on offer
    assign nxt_base = {s_r.idx + 2'h1, 9'h000};

    // Handshake and outcome outputs
    assign hsh_valid = (s_r.st != EME_IDLE);
    assign hsh_block = s_r.blk;
    assign op_busy = (s_r.st != EME_IDLE);
    assign op_done = s_r.done;
    assign op_gp_fault = s_r.gp;
    assign op_pf_fault = s_r.pf;
    assign op_pf_addr = s_r.pf_addr;
    assign reg_rdata = s_r.rdata;

    // Next-state logic for the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.gp = 1'b0;
        s_nxt.pf = 1'b0;
        s_nxt.rdata = 32'h0000_0000;

        // Checks in fixed priority; first failing one wins
        if (take) begin
            s_nxt.last_gp = 1'b0;
            s_nxt.last_pf = 1'b0;
            if (op_priv != 2'h0) begin
                s_nxt.gp = 1'b1;
            end else if (addr_gp) begin
                s_nxt.gp = 1'b1;
            end else if (op_ctrl_addr[11:0] != 12'h000) begin
                s_nxt.gp = 1'b1;
            end else if (!pc_ctrl_in_cache) begin
                s_nxt.pf = 1'b1;
                s_nxt.pf_addr = op_ctrl_addr;
            end else if ((op_chunk_addr[7:0] & EME_CHUNK_MASK) != 8'h00) begin
                s_nxt.gp = 1'b1;
            end else if (!pc_chunk_in_cache) begin
                s_nxt.pf = 1'b1;
                s_nxt.pf_addr = op_chunk_addr;
            end else if (pc_map_busy) begin
                s_nxt.gp = 1'b1;
            end else if (!pc_map_valid) begin
                s_nxt.pf = 1'b1;
                s_nxt.pf_addr = op_chunk_addr;
            end else if (!type_ok) begin
                s_nxt.pf = 1'b1;
                s_nxt.pf_addr = op_chunk_addr;
            end else if (!pc_owner_match) begin
                s_nxt.gp = 1'b1;
            end else if (pc_meas_busy || pc_init_busy) begin
                s_nxt.gp = 1'b1;
            end else if (pc_initialized) begin
                s_nxt.gp = 1'b1;
            end else begin
                // All checks passed: build header and start
                s_nxt.ofs = ofs_calc;
                s_nxt.blk = {384'h0, ofs_calc, EME_TAG};
                s_nxt.chunk = pc_chunk_data;
                s_nxt.idx = 2'h0;
                s_nxt.st = EME_HDR;
            end
            s_nxt.last_gp = s_nxt.gp;
            s_nxt.last_pf = s_nxt.pf;
        end

        // Hash step sequencing
        case (s_r.st)
            EME_HDR: begin
                if (hsh_acc) begin
                    s_nxt.cnt = s_r.cnt + EME_HDR_INC;
                    s_nxt.blk = s_r.chunk[511:0];
                    s_nxt.st = EME_DATA;
                end
            end
            EME_DATA: begin
                if (hsh_acc) begin
                    if (s_r.idx == EME_LAST_CHUNK) begin
                        s_nxt.cnt = s_r.cnt + EME_DATA_INC;
                        s_nxt.done = 1'b1;
                        s_nxt.st = EME_IDLE;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                        s_nxt.blk = s_r.chunk[nxt_base +: 512];
                    end
                end
            end
            default: begin
            end
        endcase

        // Register writes; counter clear only while idle
        if (reg_we) begin
            if (reg_addr == EME_CTRL_OFS) begin
                s_nxt.en = reg_wdata[EME_CTRL_EN_BIT];
                if (reg_wdata[EME_CTRL_CLR_BIT] && s_r.st == EME_IDLE) begin
                    s_nxt.cnt = 64'h0000_0000_0000_0000;
                end
            end
        end

        // Register reads, answered next cycle
        if (reg_re) begin
            if (reg_addr == EME_CTRL_OFS) begin
                s_nxt.rdata = {31'h0, s_r.en};
            end else if (reg_addr == EME_STAT_OFS) begin
                s_nxt.rdata = {27'h0, s_r.idx, s_r.last_pf, s_r.last_gp,
                    op_busy};
            end else if (reg_addr == EME_CNT_LO_OFS) begin
                s_nxt.rdata = s_r.cnt[31:0];
            end else if (reg_addr == EME_CNT_HI_OFS) begin
                s_nxt.rdata = s_r.cnt[63:32];
            end else if (reg_addr == EME_OFS_LO_OFS) begin
                s_nxt.rdata = s_r.ofs[31:0];
            end else if (reg_addr == EME_OFS_HI_OFS) begin
                s_nxt.rdata = s_r.ofs[63:32];
            end else begin
                s_nxt.rdata = 32'h0000_0000;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.st <= EME_IDLE;
            s_r.en <= EME_EN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Other leaf codes leave the block idle and silent
    AST_OTHER_LEAF: assert property (
        (op_req && op_leaf != EME_LEAF_CODE && s_r.st == EME_IDLE)
        |=> (s_r.st == EME_IDLE && !op_gp_fault && !op_pf_fault))
        else $error("other leaf code started the extend");

    // Nonzero privilege is a general-protection fault
    AST_PRIV: assert property (
        (take && op_priv != 2'h0) |=> (op_gp_fault && !op_pf_fault))
        else $error("privilege check missed");

    // Misaligned control address faults as protection error
    AST_CTRL_ALIGN: assert property (
        (take && op_ctrl_addr[11:0] != 12'h000) |=> op_gp_fault)
        else $error("control address alignment missed");

    // Misaligned chunk address always faults
    AST_CHUNK_ALIGN: assert property (
        (take && op_chunk_addr[7:0] != 8'h00)
        |=> (op_gp_fault || op_pf_fault))
        else $error("chunk alignment missed");

    // Contention or initialized state always faults
    AST_BUSY_INIT: assert property (
        (take && (pc_map_busy || pc_meas_busy || pc_initialized))
        |=> (op_gp_fault || op_pf_fault))
        else $error("contention or init state not refused");

    // A fault starts no hash step and keeps the counter
    AST_FAULT_NO_HASH: assert property (
        (op_gp_fault || op_pf_fault)
        |-> (!hsh_valid && s_r.cnt == $past(s_r.cnt)))
        else $error("hash activity after a fault");

    // Header block layout while header step is offered
    AST_HDR_LAYOUT: assert property (
        (s_r.st == EME_HDR) |-> (hsh_block[63:0] == EME_TAG
        && hsh_block[127:64] == s_r.ofs && hsh_block[511:128] == '0))
        else $error("header block layout wrong");

    // Header step adds one, then first chunk is offered
    AST_HDR_COUNT: assert property (
        (s_r.st == EME_HDR && hsh_ready) |=> (s_r.cnt == $past(s_r.cnt)
        + EME_HDR_INC && hsh_block == s_r.chunk[511:0]))
        else $error("header step count wrong");

    // Last chunk step adds four and pulses done
    AST_DATA_COUNT: assert property (
        (s_r.st == EME_DATA && s_r.idx == EME_LAST_CHUNK && hsh_ready)
        |=> (s_r.cnt == $past(s_r.cnt) + EME_DATA_INC && op_done
        ##1 !op_done))
        else $error("chunk steps count wrong");

    // Control address outside the page cache faults at that address
    AST_CTRL_PF: assert property (
        (take && op_priv == 2'h0 && !addr_gp && op_ctrl_addr[11:0] == 12'h000
        && !pc_ctrl_in_cache) |=> (op_pf_fault && !op_gp_fault
        && op_pf_addr == $past(op_ctrl_addr)))
        else $error("control page fault missed");

    // A page fault reports one of the two operand addresses
    AST_PF_ADDR: assert property (
        op_pf_fault |-> (op_pf_addr == $past(op_ctrl_addr)
        || op_pf_addr == $past(op_chunk_addr)))
        else $error("page fault address wrong");

    // Invalid page-map entry of the chunk page is refused
    AST_MAP_VALID: assert property (
        (take && !pc_map_valid) |=> (op_gp_fault || op_pf_fault))
        else $error("invalid page-map entry not refused");

    // Only regular and thread-control pages are measured
    AST_PAGE_TYPE: assert property (
        (take && pc_map_type != EME_PT_REGULAR && pc_map_type != EME_PT_THREAD)
        |=> (op_gp_fault || op_pf_fault))
        else $error("bad page type not refused");

    // Control address that does not own the chunk page is refused
    AST_OWNER: assert property (
        (take && !pc_owner_match) |=> (op_gp_fault || op_pf_fault))
        else $error("foreign control structure not refused");

    // Already initialized enclave is refused
    AST_INIT_DONE: assert property (
        (take && pc_initialized) |=> (op_gp_fault || op_pf_fault))
        else $error("initialized enclave not refused");

    // Segment or canonical violations are protection faults
    AST_SEG: assert property (
        (take && addr_gp) |=> (op_gp_fault && !op_pf_fault))
        else $error("segment or canonical check missed");

    // A taken request either faults once or starts the header step
    AST_ONE_OUTCOME: assert property (
        take |=> (!(op_gp_fault && op_pf_fault)
        && ((op_gp_fault || op_pf_fault) != (s_r.st == EME_HDR))))
        else $error("request outcome not exactly one");

    // Offset kept from the operands of the taken request
    AST_OFFSET: assert property (
        (take ##1 (s_r.st == EME_HDR)) |-> (s_r.ofs
        == $past(pc_enclave_addr) - $past(pc_base_addr)
        + ($past(op_chunk_addr) & {52'h0, EME_PAGE_MASK})))
        else $error("enclave offset wrong");

    // Offered block holds while the hash engine stalls
    AST_STALL_HOLD: assert property (
        (hsh_valid && !hsh_ready) |=> (hsh_valid && $stable(hsh_block)))
        else $error("offered block changed during stall");

    // Inner chunk steps advance the index and leave the counter
    AST_DATA_STEP: assert property (
        (s_r.st == EME_DATA && s_r.idx != EME_LAST_CHUNK && hsh_ready)
        |=> (s_r.st == EME_DATA && s_r.idx == $past(s_r.idx) + 2'h1
        && s_r.cnt == $past(s_r.cnt)))
        else $error("chunk step sequencing wrong");

endmodule // eme_extend
`default_nettype wire

// File: inc/eme_pkg.sv
// Shared constants and types for the enclave measurement extend block
`default_nettype none
package eme_pkg;
    // Leaf selector, header tag, address masks, last chunk index and counter increments
    localparam logic [7:0] EME_LEAF_CODE = 8'h06;
    localparam logic [63:0] EME_TAG = 64'h0044_4E45_5458_4545;
    localparam logic [11:0] EME_PAGE_MASK = 12'hFFF;
    localparam logic [7:0] EME_CHUNK_MASK = 8'hFF;
    localparam logic [1:0] EME_LAST_CHUNK = 2'h3;
    localparam logic [63:0] EME_HDR_INC = 64'h0000_0000_0000_0001;
    localparam logic [63:0] EME_DATA_INC = 64'h0000_0000_0000_0004;
    // Page types of the page-cache map
    localparam logic [7:0] EME_PT_CTRL = 8'h00;
    localparam logic [7:0] EME_PT_THREAD = 8'h01;
    localparam logic [7:0] EME_PT_REGULAR = 8'h02;
    // Register offsets (byte addresses)
    localparam logic [7:0] EME_CTRL_OFS = 8'h00;
    localparam logic [7:0] EME_STAT_OFS = 8'h04;
    localparam logic [7:0] EME_CNT_LO_OFS = 8'h08;
    localparam logic [7:0] EME_CNT_HI_OFS = 8'h0C;
    localparam logic [7:0] EME_OFS_LO_OFS = 8'h10;
    localparam logic [7:0] EME_OFS_HI_OFS = 8'h14;
    // Field positions and enable reset value
    localparam int EME_CTRL_EN_BIT = 0;
    localparam int EME_CTRL_CLR_BIT = 1;
    localparam logic EME_EN_RST = 1'b1;
    // Sequencer states
    typedef enum logic [1:0] {
        EME_IDLE,
        EME_HDR,
        EME_DATA
    } eme_state_t;
endpackage
`default_nettype wire

// File: dv/eme_extend_bench.sv
// Self-checking bench for the measurement extend block
`default_nettype none
module eme_extend_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eme_pkg::*;
    logic sys_clk, nrst, reg_we, reg_re, op_req, op_mode64, op_busy;
    logic op_ctrl_seg_ok, op_chunk_seg_ok, pc_ctrl_in_cache, pc_map_valid;
    logic pc_chunk_in_cache, pc_owner_match, pc_initialized, pc_map_busy;
    logic pc_meas_busy, pc_init_busy, hsh_ready, hsh_valid, op_done;
    logic op_gp_fault, op_pf_fault;
    logic [7:0] reg_addr, op_leaf, pc_map_type;
    logic [31:0] reg_wdata, reg_rdata, seed, d;
    logic [31:0] rdy_s = 32'h0000_0053;
    logic [1:0] op_priv;
    logic [63:0] op_ctrl_addr, op_chunk_addr, pc_enclave_addr, pc_base_addr;
    logic [63:0] op_pf_addr, ctrl, chunk, cnt, pa;
    logic [2047:0] pc_chunk_data;
    logic [511:0] hsh_block;
    logic [511:0] expq[$];
    logic [2:0] res;
    int miscompares, n_tests, k, kind;

    eme_extend u_eme_extend (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_we,
        .reg_re, .reg_rdata, .op_req, .op_leaf, .op_priv, .op_mode64,
        .op_ctrl_addr, .op_chunk_addr, .op_ctrl_seg_ok, .op_chunk_seg_ok,
        .pc_ctrl_in_cache, .pc_chunk_in_cache, .pc_map_valid, .pc_map_type,
        .pc_owner_match, .pc_initialized, .pc_map_busy, .pc_meas_busy,
        .pc_init_busy, .pc_enclave_addr, .pc_base_addr, .pc_chunk_data,
        .op_busy, .op_done, .op_gp_fault, .op_pf_fault, .op_pf_addr,
        .hsh_valid, .hsh_block, .hsh_ready);

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] rnd();
        seed = lfsr(seed);
        return seed;
    endfunction

    // Hash engine stalls about a quarter of the time
    always @(posedge sys_clk) begin
        rdy_s <= lfsr(rdy_s);
        hsh_ready <= rdy_s[0] | rdy_s[3];
    end

    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [511:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s", $time, m);
            miscompares++;
        end
    endtask

    // Register port cycles
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge sys_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        @(negedge sys_clk);
        q = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask
    task automatic chk_cnt();
        rd(EME_CNT_LO_OFS, d);
        chk(d, cnt[31:0], "counter low");
        rd(EME_CNT_HI_OFS, d);
        chk(d, cnt[63:32], "counter high");
    endtask

    // Legal operands with random addresses, type and page data
    task automatic set_good(input logic m64);
        int i;
        logic [31:0] r;
        r = rnd();
        ctrl = {32'h0000_0000, r[19:0], 12'h000};
        chunk = {32'h0000_0000, r[31:24], 12'h000, r[27:24], 8'h00};
        @(posedge sys_clk);
        op_leaf <= EME_LEAF_CODE;
        op_priv <= 2'h0;
        op_mode64 <= m64;
        op_ctrl_addr <= ctrl;
        op_chunk_addr <= chunk;
        {op_ctrl_seg_ok, op_chunk_seg_ok, pc_ctrl_in_cache} <= 3'h7;
        {pc_chunk_in_cache, pc_map_valid, pc_owner_match} <= 3'h7;
        {pc_initialized, pc_map_busy, pc_meas_busy, pc_init_busy} <= 4'h0;
        pc_map_type <= r[0] ? EME_PT_THREAD : EME_PT_REGULAR;
        pc_enclave_addr <= {rnd(), rnd()};
        pc_base_addr <= {rnd(), rnd()};
        for (i = 0; i < 64; i++) pc_chunk_data[i*32 +: 32] <= rnd();
    endtask

    // Pulse a request; report the first outcome pulse seen
    task automatic run_op(input int hold, output logic [2:0] r);
        int n;
        @(posedge sys_clk);
        op_req <= 1'b1;
        repeat (hold) @(posedge sys_clk);
        op_req <= 1'b0;
        r = 3'h0;
        for (n = 0; n < 40 && r === 3'h0; n++) begin
            @(negedge sys_clk);
            r = {op_gp_fault, op_pf_fault, op_done};
        end
    endtask

    task automatic good_op(input logic m64, input int hold);
        logic [63:0] off;
        int j;
        set_good(m64);
        @(negedge sys_clk);
        off = pc_enclave_addr - pc_base_addr + {52'h0, op_chunk_addr[11:0]};
        expq.push_back({384'h0, off, EME_TAG});
        for (j = 0; j < 4; j++) expq.push_back(pc_chunk_data[j*512 +: 512]);
        run_op(hold, res);
        chk(res, 3'h1, "extend outcome");
        chk(op_busy, 1'b0, "busy after done");
        chk(expq.size(), 0, "hash steps missing");
        cnt = cnt + 64'h5;
        chk_cnt();
        rd(EME_OFS_LO_OFS, d);
        chk(d, off[31:0], "offset low");
        rd(EME_OFS_HI_OFS, d);
        chk(d, off[63:32], "offset high");
    endtask

    // Break exactly one check; kind 1 general protection, 2 page fault
    task automatic fault_case(input int c, output int kd,
        output logic [63:0] a);
        kd = (c == 4 || c == 6 || c == 8 || c == 9 || c == 10) ? 2 : 1;
        a = (c == 4) ? ctrl : chunk;
        case (c)
            0: op_priv <= 2'h3;
            1: op_chunk_addr <= {1'b1, chunk[62:0]};
            2: {op_mode64, op_ctrl_seg_ok} <= 2'h0;
            3: op_ctrl_addr <= ctrl | 64'h0000_0000_0000_0800;
            4: pc_ctrl_in_cache <= 1'b0;
            5: op_chunk_addr <= chunk | 64'h0000_0000_0000_0040;
            6: pc_chunk_in_cache <= 1'b0;
            7: pc_map_busy <= 1'b1;
            8: pc_map_valid <= 1'b0;
            9: pc_map_type <= EME_PT_CTRL;
            10: pc_map_type <= 8'h07;
            11: pc_owner_match <= 1'b0;
            12: pc_meas_busy <= 1'b1;
            13: pc_init_busy <= 1'b1;
            default: pc_initialized <= 1'b1;
        endcase
    endtask

    // Every accepted hash block must be the next expected one
    always @(negedge sys_clk) begin
        if (hsh_valid === 1'b1 && hsh_ready === 1'b1) begin
            chk(op_busy, 1'b1, "busy flag");
            if (expq.size() == 0) chk(1, 0, "hash step not expected");
            else chk(hsh_block, expq.pop_front(), "hash block");
        end
    end

    // Main sequence
    initial begin
        {nrst, reg_we, reg_re, op_req} = 4'h0;
        {reg_addr, reg_wdata} = {8'h00, 32'h0000_0000};
        seed = 32'h0000_0053;
        cnt = 64'h0;
        set_good(1'b1);
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(EME_CTRL_OFS, d);
        chk(d[0], EME_EN_RST, "enable reset value");
        chk_cnt();
        good_op(1'b1, 2);
        good_op(1'b0, 1);
        set_good(1'b1);
        @(posedge sys_clk);
        op_leaf <= 8'h05;
        run_op(1, res);
        chk(res, 3'h0, "foreign leaf answered");
        wr(EME_CTRL_OFS, 32'h0000_0000);
        set_good(1'b1);
        run_op(1, res);
        chk(res, 3'h0, "request taken while disabled");
        wr(EME_CTRL_OFS, 32'h0000_0001);
        for (k = 0; k < 15; k++) begin
            set_good(1'b1);
            @(posedge sys_clk);
            fault_case(k, kind, pa);
            run_op(1, res);
            chk(res, (kind == 2) ? 3'h2 : 3'h4, "fault kind");
            if (kind == 2) chk(op_pf_addr, pa, "fault address");
            rd(EME_STAT_OFS, d);
            chk(d[2:1], (kind == 2) ? 2'h2 : 2'h1, "status kind");
        end
        chk_cnt();
        rd(8'h20, d);
        chk(d, 32'h0, "unmapped read");
        wr(EME_CTRL_OFS, 32'h0000_0003);
        cnt = 64'h0;
        chk_cnt();
        conclude();
    end

    // Watchdog
    initial begin
        #80000;
        miscompares++;
        conclude();
    end
endmodule // eme_extend_bench
`default_nettype wire
